// file: src/adcc_pkg.sv
// package: register map, field positions and constants of the converter control
package adcc_pkg;
    // ***************************************************
    // register byte addresses (word aligned)
    // ***************************************************
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'h00;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_MAIN_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_SRC_CLK     = 8'h0C;
    localparam logic [7:0] ADDR_REF_GAIN    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h1C;
    localparam logic [7:0] ADDR_PIN_ANALOG  = 8'h20;

    // ***************************************************
    // main control fields
    // ***************************************************
    localparam int BIT_START   = 7;
    localparam int BIT_BUSY    = 6;
    localparam int BIT_ENABLE  = 5;
    localparam int BIT_JUSTIFY = 4;

    // ***************************************************
    // reset values and masks
    // ***************************************************
    localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
    localparam logic [7:0] RST_SRC_CLK   = 8'h00;
    localparam logic [7:0] RST_REF_GAIN  = 8'h00;
    localparam logic [7:0] RST_PIN_ANA   = 8'h00;
    localparam logic [7:0] MASK_SRC_CLK  = 8'hF7;
    localparam logic [7:0] MASK_REF_GAIN = 8'h9F;

    localparam int RESULT_W   = 12;
    localparam int CHAN_NUM   = 8;
    localparam int CONV_TICKS = 14;  // converter clocks per conversion

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_DONE
    } adcc_state_t;
endpackage

// file: src/adcc_top.sv
// adc control and result register block with an axi4-lite slave
`timescale 1ns/1ns
module adcc_top
    import adcc_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_TICKS
) (
    // clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                sys_rst_i,
    // axi4-lite write address
    input  wire logic [7:0]          s_axi_awaddr_i,
    input  wire logic                s_axi_awvalid_i,
    output logic                     s_axi_awready_o,
    // axi4-lite write data
    input  wire logic [31:0]         s_axi_wdata_i,
    input  wire logic [3:0]          s_axi_wstrb_i,
    input  wire logic                s_axi_wvalid_i,
    output logic                     s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0]               s_axi_bresp_o,
    output logic                     s_axi_bvalid_o,
    input  wire logic                s_axi_bready_i,
    // axi4-lite read address
    input  wire logic [7:0]          s_axi_araddr_i,
    input  wire logic                s_axi_arvalid_i,
    output logic                     s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0]              s_axi_rdata_o,
    output logic [1:0]               s_axi_rresp_o,
    output logic                     s_axi_rvalid_o,
    input  wire logic                s_axi_rready_i,
    // analog core
    output logic                     conv_power_o,
    output logic                     conv_start_o,
    output logic                     conv_clk_en_o,
    output logic [3:0]               input_source_select_o,
    output logic [7:0]               reference_gain_o,
    input  wire logic [RESULT_W-1:0] conv_result_i,
    // analog pin mux
    output logic [CHAN_NUM-1:0]      chan_connect_o,
    output logic [CHAN_NUM-1:0]      pin_digital_en_o,
    output logic [CHAN_NUM-1:0]      pin_pullhigh_allow_o,
    // interrupt
    output logic                     irq_o
);
    // elaboration check: the tick counter is eight bits wide, so a
    // conversion may last 1 to 255 converter clocks
    if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin : g_bad_cycles
        $error("CONV_CYCLES must lie between 1 and 255");
    end

    // ***************************************************
    // state record
    // ***************************************************
    // every flop of the block lives in this one record
    typedef struct packed {
        logic [7:0]          main_ctrl;
        logic [7:0]          src_clk;
        logic [7:0]          ref_gain;
        logic [7:0]          pin_ana;
        logic [RESULT_W-1:0] result;
        logic                irq_stat;
        logic                irq_en;
        adcc_state_t         state;
        logic [6:0]          div_cnt;
        logic [7:0]          tick_cnt;
        logic                start_pulse;
        logic                aw_held;
        logic [7:0]          aw_addr;
        logic                w_held;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
    } adcc_regs_t;

    adcc_regs_t r;
    adcc_regs_t next_r;

    // ***************************************************
    // helper functions
    // ***************************************************
    // expected external source per source select code
    function automatic logic src_is_external(input logic [3:0] code);
        return (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'b11);
    endfunction

    // justified result bytes: {high, low}
    function automatic logic [15:0] justify(input logic [RESULT_W-1:0] d,
                                            input logic j);
        if (j) begin
            return {4'h0, d};
        end
        return {d, 4'h0};
    endfunction

    // ***************************************************
    // shared decode
    // ***************************************************
    logic [15:0] res_bytes;
    logic        tick;
    logic        wr_go;
    logic        rd_go;
    logic [6:0]  div_mask;

    // justified bytes, divider compare and bus launch conditions
    always_comb begin
        res_bytes = justify(r.result, r.main_ctrl[BIT_JUSTIFY]);
        // divider reload mask 2^n - 1 picks the converter clock rate
        div_mask  = 7'((8'h01 << r.src_clk[2:0]) - 8'h01);
        tick      = (r.div_cnt == div_mask);
        // a write waits while its response is still unanswered
        wr_go     = r.aw_held && r.w_held && !r.bvalid;
        rd_go     = s_axi_arvalid_i && !r.rvalid;
    end

    // ***************************************************
    // next-state logic
    // ***************************************************
    always_comb begin
        logic [7:0] wb;
        logic       clear_irq;
        logic       done_evt;
        logic [7:0] rv;
        wb        = 8'h00;
        clear_irq = 1'b0;
        done_evt  = 1'b0;
        rv        = 8'h00;
        next_r    = r;
        next_r.start_pulse = 1'b0;

        // conversion clock divider runs only while enabled (power saving)
        // after switch-on the first tick comes a full divided period later
        if (!r.main_ctrl[BIT_ENABLE] || tick) begin
            next_r.div_cnt = 7'h00;
        end else begin
            next_r.div_cnt = r.div_cnt + 7'h01;
        end

        // ***************************************************
        // bus write
        // ***************************************************
        // readies come from the slot flags alone: no valid-to-ready path
        // axi write capture: address and data in either order
        if (s_axi_awvalid_i && !r.aw_held) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !r.w_held) begin
            next_r.w_held = 1'b1;
            next_r.w_data = s_axi_wdata_i;
            next_r.w_strb = s_axi_wstrb_i;
        end
        if (r.bvalid && s_axi_bready_i) begin
            next_r.bvalid = 1'b0;
        end

        // register write, only byte lane 0 carries data
        if (wr_go) begin
            next_r.aw_held = 1'b0;
            next_r.w_held  = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = RESP_OKAY;
            wb = r.w_data[7:0];
            case (r.aw_addr)
                ADDR_MAIN_CTRL: begin
                    if (r.w_strb[0]) begin
                        // falling start bit after a high one launches;
                        // the launching write must leave the converter on
                        if (r.main_ctrl[BIT_START] && !wb[BIT_START] &&
                            r.main_ctrl[BIT_ENABLE] && wb[BIT_ENABLE] &&
                            r.state == ST_IDLE) begin
                            next_r.start_pulse = 1'b1;
                        end
                        next_r.main_ctrl = {wb[7],
                                            r.main_ctrl[BIT_BUSY],
                                            wb[5:0]};
                    end
                end
                ADDR_SRC_CLK: begin
                    if (r.w_strb[0]) begin
                        next_r.src_clk = wb & MASK_SRC_CLK;
                    end
                end
                ADDR_REF_GAIN: begin
                    if (r.w_strb[0]) begin
                        next_r.ref_gain = wb & MASK_REF_GAIN;
                    end
                end
                ADDR_PIN_ANALOG: begin
                    if (r.w_strb[0]) begin
                        next_r.pin_ana = wb;
                    end
                end
                ADDR_IRQ_ENABLE: begin
                    if (r.w_strb[0]) begin
                        next_r.irq_en = wb[0];
                    end
                end
                ADDR_IRQ_CLEAR: begin
                    clear_irq = r.w_strb[0] && wb[0];
                end
                ADDR_RESULT_LOW, ADDR_RESULT_HIGH,
                ADDR_IRQ_STATUS: begin
                    next_r.bresp = RESP_OKAY;                 // read-only
                end
                default: begin
                    next_r.bresp = RESP_SLVERR;
                end
            endcase
        end

        // ***************************************************
        // conversion sequencer
        // ***************************************************
        // one conversion at a time; a start while busy is ignored
        case (r.state)
            ST_IDLE: begin
                if (r.start_pulse) begin
                    next_r.state    = ST_CONV;
                    next_r.tick_cnt = 8'h00;
                    next_r.main_ctrl[BIT_BUSY] = 1'b1;
                end
            end
            ST_CONV: begin
                if (!r.main_ctrl[BIT_ENABLE]) begin
                    // abort: results stay as they were
                    next_r.state = ST_IDLE;
                    next_r.main_ctrl[BIT_BUSY] = 1'b0;
                end else if (tick) begin
                    // one tick is one converter clock
                    if (r.tick_cnt == 8'(CONV_CYCLES - 1)) begin
                        next_r.state = ST_DONE;
                    end else begin
                        next_r.tick_cnt = r.tick_cnt + 8'h01;
                    end
                end
            end
            ST_DONE: begin
                // result and busy clear land on the same edge; a
                // switch-off on the edge before must not land a code
                if (r.main_ctrl[BIT_ENABLE]) begin
                    next_r.result = conv_result_i;
                    done_evt      = 1'b1;
                end
                next_r.main_ctrl[BIT_BUSY] = 1'b0;
                next_r.state = ST_IDLE;
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase

        // ***************************************************
        // interrupt flag
        // ***************************************************
        // sticky flag: a new event beats a clear in the same cycle
        if (done_evt) begin
            next_r.irq_stat = 1'b1;
        end else if (clear_irq) begin
            next_r.irq_stat = 1'b0;
        end

        // ***************************************************
        // bus read
        // ***************************************************
        // data is taken from the registers as they stand when accepted
        if (r.rvalid && s_axi_rready_i) begin
            next_r.rvalid = 1'b0;
        end
        if (rd_go) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = RESP_OKAY;
            case (s_axi_araddr_i)
                ADDR_RESULT_LOW:  rv = res_bytes[7:0];
                ADDR_RESULT_HIGH: rv = res_bytes[15:8];
                ADDR_MAIN_CTRL:   rv = r.main_ctrl;
                ADDR_SRC_CLK:     rv = r.src_clk;
                ADDR_REF_GAIN:    rv = r.ref_gain;
                ADDR_PIN_ANALOG:  rv = r.pin_ana;
                ADDR_IRQ_STATUS:  rv = {7'h00, r.irq_stat};
                ADDR_IRQ_ENABLE:  rv = {7'h00, r.irq_en};
                ADDR_IRQ_CLEAR:   rv = 8'h00;
                default: begin
                    next_r.rresp = RESP_SLVERR;
                end
            endcase
            next_r.rdata = {24'h00_0000, rv};
        end
    end

    // ***************************************************
    // state register
    // ***************************************************
    // reset zeroes every slot, which is also the idle bus state
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r           <= '0;
            r.main_ctrl <= RST_MAIN_CTRL;
            r.src_clk   <= RST_SRC_CLK;
            r.ref_gain  <= RST_REF_GAIN;
            r.pin_ana   <= RST_PIN_ANA;
            r.state     <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    // bus handshakes: accept whenever the holding slot is free
    assign s_axi_awready_o = !r.aw_held;
    assign s_axi_wready_o  = !r.w_held;
    assign s_axi_bvalid_o  = r.bvalid;
    assign s_axi_bresp_o   = r.bresp;
    assign s_axi_arready_o = !r.rvalid;
    assign s_axi_rvalid_o  = r.rvalid;
    assign s_axi_rresp_o   = r.rresp;
    assign s_axi_rdata_o   = r.rdata;

    // analog core controls
    assign conv_power_o          = r.main_ctrl[BIT_ENABLE];
    assign conv_start_o          = (r.state == ST_IDLE) && r.start_pulse;
    assign conv_clk_en_o         = tick && (r.state == ST_CONV);
    assign input_source_select_o = r.src_clk[7:4];
    assign reference_gain_o      = r.ref_gain;
    // level interrupt: no flop of its own, so a clear drops it at once
    assign irq_o                 = r.irq_stat && r.irq_en;

    // ***************************************************
    // pin routing
    // ***************************************************
    // codes 8 to 15 connect nothing and leave the input floating
    // pin mux: the channel connects only when the pin is analog,
    // the source is external and the code is 0..7; leaves the
    // ordering to software, a pin not yet analog stays disconnected
    always_comb begin
        chan_connect_o = '0;
        if (src_is_external(r.src_clk[7:4]) &&
            !r.main_ctrl[3]) begin
            chan_connect_o[r.main_ctrl[2:0]] =
                r.pin_ana[r.main_ctrl[2:0]];
        end
    end
    assign pin_digital_en_o     = ~r.pin_ana;
    assign pin_pullhigh_allow_o = ~r.pin_ana;
endmodule

// file: tb/adcc_core_model.sv
// analog core model: freezes its input at each start, presents a 12-bit code
`timescale 1ns/1ns
module adcc_core_model (
    // converter controls
    input  wire logic        clk_sys_i,
    input  wire logic        conv_power_i,
    input  wire logic        conv_start_i,
    // level on the selected input, already as a code
    input  wire logic [11:0] sample_i,
    // digitised code
    output logic      [11:0] conv_result_o
);
    logic [11:0] held;
    // frozen at the start so a moving input cannot tear the code
    always_ff @(posedge clk_sys_i) begin
        if (conv_start_i && conv_power_i) begin
            held <= sample_i;
        end
    end
    // switched off: no valid code, so show a pattern rather than a stale one
    assign conv_result_o = conv_power_i ? held : ~held;
endmodule

// file: tb/adcc_sva.sv
// checker: port-level assertions for the converter control block
`timescale 1ns/1ns
module adcc_sva_chk #(
    parameter int CONV_CYCLES = 14
) (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    // bus answers
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // converter and pins
    input wire logic        conv_power_o,
    input wire logic        conv_start_o,
    input wire logic [3:0]  input_source_select_o,
    input wire logic [7:0]  chan_connect_o,
    input wire logic [7:0]  pin_digital_en_o,
    input wire logic [7:0]  pin_pullhigh_allow_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // source codes that route an external pin to the converter
    wire ext_src = input_source_select_o inside {4'h0, 4'h4, [4'hC:4'hF]};
    sequence s_start;
        conv_start_o;
    endsequence
    // a new start needs two more bus writes, so the pulse stands alone
    sequence s_quiet;
        !conv_start_o [*3];
    endsequence
    a_pin_analog: assert property
        ((chan_connect_o & pin_digital_en_o) == 0)
        else $error("connected pin keeps its digital function");
    a_pull_removed: assert property
        (pin_pullhigh_allow_o == pin_digital_en_o)
        else $error("pull-high not removed with digital function");
    a_chan_single: assert property ($onehot0(chan_connect_o))
        else $error("more than one channel connected");
    a_internal_off: assert property
        (!ext_src && $stable(input_source_select_o) |-> chan_connect_o == 0)
        else $error("internal source left a pin connected");
    a_start_power: assert property (conv_start_o |-> conv_power_o)
        else $error("conversion started while switched off");
    a_start_single: assert property (s_start |=> s_quiet)
        else $error("start pulse repeated");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    a_rdata_upper: assert property
        (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 0)
        else $error("unused read bits not zero");
    a_reset_idle: assert property (disable iff (1'b0) sys_rst_i
        |=> !irq_o && !conv_power_o && chan_connect_o == 0)
        else $error("outputs not idle after reset");
endmodule

// file: tb/testbench.sv
// testbench: register-level tests of the converter control block
`timescale 1ns/1ns
module testbench;
    import adcc_pkg::*;
    localparam int CC = 2;  // short conversion keeps the run brief
    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr_i = 8'h00;
    logic [7:0]  s_axi_araddr_i = 8'h00;
    logic        s_axi_awvalid_i = 1'b0;
    logic        s_axi_wvalid_i = 1'b0;
    logic        s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0;
    logic        s_axi_rready_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic        s_axi_arready_o, s_axi_rvalid_o, irq_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
    logic [31:0] s_axi_rdata_o, rv;
    logic        conv_power_o, conv_start_o, conv_clk_en_o;
    logic [3:0]  input_source_select_o;
    logic [7:0]  reference_gain_o, chan_connect_o;
    logic [7:0]  pin_digital_en_o, pin_pullhigh_allow_o;
    logic [11:0] conv_result_i, sample = 12'h000;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_ticks = 0;

    adcc_top #(.CONV_CYCLES(CC)) dut (.clk_sys_i, .sys_rst_i,
        .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
        .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
        .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i, .conv_power_o, .conv_start_o, .conv_clk_en_o,
        .input_source_select_o, .reference_gain_o, .conv_result_i,
        .chan_connect_o, .pin_digital_en_o, .pin_pullhigh_allow_o, .irq_o);
    adcc_core_model u_core (.clk_sys_i, .conv_power_i(conv_power_o),
        .conv_start_i(conv_start_o), .sample_i(sample),
        .conv_result_o(conv_result_i));

    always #2 clk_sys_i = ~clk_sys_i;

    // converter clock pulses, so each conversion is held to its count
    always @(posedge clk_sys_i) begin
        if (conv_clk_en_o === 1'b1) n_ticks <= n_ticks + 1;
    end

    // ***************************************************
    // bus tasks and comparisons
    // ***************************************************
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // readies are sampled at the falling edge, where they have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (b !== 1'b1) begin
            @(negedge clk_sys_i);
            aw = s_axi_awvalid_i && s_axi_awready_o;
            w = s_axi_wvalid_i && s_axi_wready_o;
            b = s_axi_bvalid_o;
            resp = s_axi_bresp_o;
            @(posedge clk_sys_i);
            if (aw) s_axi_awvalid_i <= 1'b0;
            if (w) s_axi_wvalid_i <= 1'b0;
        end
        s_axi_bready_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ar, r;
        r = 1'b0;
        @(posedge clk_sys_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        while (r !== 1'b1) begin
            @(negedge clk_sys_i);
            ar = s_axi_arvalid_i && s_axi_arready_o;
            r = s_axi_rvalid_o;
            rv = s_axi_rdata_o;
            resp = s_axi_rresp_o;
            @(posedge clk_sys_i);
            if (ar) s_axi_arvalid_i <= 1'b0;
        end
        s_axi_rready_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        rd(a);
        chk(nm, e, rv);
    endtask
    task automatic start(input logic [7:0] c);
        wr(ADDR_MAIN_CTRL, 32'(c | 8'h80));
        wr(ADDR_MAIN_CTRL, 32'(c));
    endtask
    // polling is bounded only by the watchdog, as a real driver would be
    task automatic conv(input logic [11:0] s, input logic [7:0] c);
        int t0;
        t0 = n_ticks;
        sample = s;
        start(c);
        rchk("busy set", ADDR_MAIN_CTRL, 32'(c | 8'h40));
        wr(ADDR_MAIN_CTRL, 32'(c));
        rchk("busy kept", ADDR_MAIN_CTRL, 32'(c | 8'h40));
        do rd(ADDR_MAIN_CTRL); while (rv[BIT_BUSY] === 1'b1);
        chk("busy clear", 32'(c), rv);
        chk("tick count", 32'(CC), 32'(n_ticks - t0));
    endtask
    task automatic tdone(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        #100000;
        n_mismatch++;
        close_out;
    end

    // ***************************************************
    // test sequence
    // ***************************************************
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rchk("main reset", ADDR_MAIN_CTRL, 32'h0000_0000);
        rchk("src reset", ADDR_SRC_CLK, 32'h0000_0000);
        rchk("irq reset", ADDR_IRQ_STATUS, 32'h0000_0000);
        rd(8'h24);
        chk("bad read", 32'(RESP_SLVERR), 32'(resp));
        wr(8'h24, 32'h0000_00FF);
        chk("bad write", 32'(RESP_SLVERR), 32'(resp));
        wr(ADDR_MAIN_CTRL, 32'h0000_0040);
        rchk("busy ro", ADDR_MAIN_CTRL, 32'h0000_0000);
        wr(ADDR_REF_GAIN, 32'h0000_00FF);
        rchk("ref gain", ADDR_REF_GAIN, 32'(MASK_REF_GAIN));
        chk("gain out", 32'(MASK_REF_GAIN), 32'(reference_gain_o));
        tdone("registers");
        // pins go analog before any channel is picked
        wr(ADDR_PIN_ANALOG, 32'h0000_00FF);
        chk("digital off", 32'h0000_0000, 32'(pin_digital_en_o));
        chk("pull off", 32'h0000_0000, 32'(pin_pullhigh_allow_o));
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_MAIN_CTRL, 32'(c));
            chk("chan", c < 8 ? 32'(1) << c : 0, 32'(chan_connect_o));
        end
        wr(ADDR_MAIN_CTRL, 32'h0000_0003);
        wr(ADDR_SRC_CLK, 32'h0000_0010);
        chk("internal", 32'h0000_0000, 32'(chan_connect_o));
        chk("src out", 32'h0000_0001, 32'(input_source_select_o));
        wr(ADDR_SRC_CLK, 32'h0000_00C7);
        chk("ext code", 32'h0000_0008, 32'(chan_connect_o));
        tdone("channels");
        wr(ADDR_IRQ_ENABLE, 32'h0000_0001);
        conv(12'hA5C, 8'h23);
        chk("power on", 32'h0000_0001, 32'(conv_power_o));
        rchk("high left", ADDR_RESULT_HIGH, 32'h0000_00A5);
        rchk("low left", ADDR_RESULT_LOW, 32'h0000_00C0);
        chk("irq on", 32'h0000_0001, 32'(irq_o));
        wr(ADDR_IRQ_CLEAR, 32'h0000_0001);
        chk("irq clear", 32'h0000_0000, 32'(irq_o));
        wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
        conv(12'h3E7, 8'h33);
        rchk("high right", ADDR_RESULT_HIGH, 32'h0000_0003);
        rchk("low right", ADDR_RESULT_LOW, 32'h0000_00E7);
        rchk("status", ADDR_IRQ_STATUS, 32'h0000_0001);
        chk("irq masked", 32'h0000_0000, 32'(irq_o));
        tdone("conversions");
        // justify stays right so the kept code reads back unchanged
        sample = 12'h111;
        start(8'h13);
        rchk("idle off", ADDR_MAIN_CTRL, 32'h0000_0013);
        chk("power off", 32'h0000_0000, 32'(conv_power_o));
        rchk("high kept", ADDR_RESULT_HIGH, 32'h0000_0003);
        rchk("low kept", ADDR_RESULT_LOW, 32'h0000_00E7);
        // switch-off in mid-conversion: busy drops, no code lands
        start(8'h33);
        rchk("abort busy", ADDR_MAIN_CTRL, 32'h0000_0073);
        wr(ADDR_MAIN_CTRL, 32'h0000_0013);
        rchk("abort idle", ADDR_MAIN_CTRL, 32'h0000_0013);
        rchk("high abort", ADDR_RESULT_HIGH, 32'h0000_0003);
        rchk("low abort", ADDR_RESULT_LOW, 32'h0000_00E7);
        tdone("disabled");
        close_out;
    end
endmodule

bind adcc_top adcc_sva_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.clk_sys_i,
    .sys_rst_i, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .conv_power_o,
    .conv_start_o, .input_source_select_o, .chan_connect_o,
    .pin_digital_en_o, .pin_pullhigh_allow_o, .irq_o);
